/* File: logic/dwa_pkg.sv */
// Constants, types and helpers for the debug wire handshake abort block.
// Assumes one system clock and a serial clock derived from it by a divider.
// Overview of operation
// - Acknowledge waits forever; no timeout exists.
// - Stop or wait discards pending run-until-active.
// - Long low runs sync, aborts pending command.
// - Started memory access completes; only acknowledge dropped.
// - Run and step commands keep running; acknowledge dropped.
// - Short low aborts command and acknowledge, no sync.
// - Falling edge on pin cancels outstanding acknowledge.
// - Pulse hidden by acknowledge starts a new command.
package dwa_pkg;

	// Serial clock cycles of low that make a synchronisation request.
	localparam logic [7:0] SYNC_LOW_MIN  = 8'h80;
	// Length of the reference pulse, in serial clock cycles.
	localparam logic [7:0] SYNC_REF_LEN  = 8'h80;
	// Quiet gap before the reference pulse, in serial clock cycles.
	localparam logic [7:0] SYNC_GAP_LEN  = 8'h10;
	// Length of the acknowledge low pulse, in serial clock cycles.
	localparam logic [7:0] ACK_LEN       = 8'h10;
	// System cycles in which the pin is not watched after a release.
	localparam logic [1:0] GUARD_CYCLES  = 2'h3;

	// Kinds of command that the command decoder may leave pending.
	typedef enum logic [2:0] {
		CMD_READ,
		CMD_WRITE,
		CMD_RUN,
		CMD_STEP,
		CMD_RUN_UNTIL,
		CMD_OTHER
	} dwaCmdKind_t;

	// A command that the decoder has taken and now waits on.
	typedef struct packed {
		logic        start;
		dwaCmdKind_t kind;
	} dwaCmdReq_t;

	// Drive of the debug pin: level and output enable.
	typedef struct packed {
		logic out;
		logic oe;
	} dwaPinDrv_t;

	// Pin sequencer states.
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_HOST_LOW,
		ST_SYNC_GAP,
		ST_SYNC_REF,
		ST_ACK,
		ST_SPEEDUP
	} dwaState_t;

	// True for commands that set the core running and that a host low pulse does not abort.
	function automatic logic dwaIsRunKind(input dwaCmdKind_t kind);
		return (kind == CMD_RUN) || (kind == CMD_STEP) ||
			(kind == CMD_RUN_UNTIL);
	endfunction

endpackage

/* File: logic/dwa_handshake_abort.sv */
// Acknowledge, abort and synchronisation logic for the single wire debug pin.
// Assumes a command decoder beside it that reports each command taken, the
// start of its memory access, and its completion, and honours the abort.
`timescale 1ns/10ps
module dwa_handshake_abort
	import dwa_pkg::*;
#(
	parameter int SER_DIV = 4
) (
	input  wire logic       sys_clk,
	input  wire logic       reset,
	input  wire logic       debugPinIn,
	input  wire dwaCmdReq_t cmdReq,
	input  wire logic       accessBegin,
	input  wire logic       cmdDone,
	input  wire logic       stopWaitExec,
	output dwaPinDrv_t      pinDrv,
	output logic            cmdAbort,
	output logic            cmdBitStart,
	output logic            syncBusy,
	output logic            syncDone,
	output logic            cmdPending
);

	localparam int DIV_W = (SER_DIV > 1) ? $clog2(SER_DIV) : 1;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SER_DIV - 1);

	dwaState_t        state_r, state_nxt;
	logic [DIV_W-1:0] divCnt_r, divCnt_nxt;
	logic [7:0]       cnt_r, cnt_nxt;
	logic [1:0]       guard_r, guard_nxt;
	logic             pinSync1_r, pinSync2_r, pinPrev_r;
	logic             pend_r, pend_nxt;
	dwaCmdKind_t      kind_r, kind_nxt;
	logic             access_r, access_nxt;
	logic             ackCancel_r, ackCancel_nxt;
	logic             ackReady_r, ackReady_nxt;
	logic             inSync_r, inSync_nxt;
	dwaPinDrv_t       pinDrv_r, pinDrv_nxt;
	logic             cmdAbort_r, cmdAbort_nxt;
	logic             bitStart_r, bitStart_nxt;
	logic             syncBusy_r, syncBusy_nxt;
	logic             syncDone_r, syncDone_nxt;
	logic             serTick, pinLow, fallEdge, riseEdge, watching;

	// Two flops bring the pin into the clock domain; the second is used.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			pinSync1_r <= 1'b1;
			pinSync2_r <= 1'b1;
			pinPrev_r  <= 1'b1;
		end else begin
			pinSync1_r <= debugPinIn;
			pinSync2_r <= pinSync1_r;
			pinPrev_r  <= pinSync2_r;
		end
	end

	// Edges are only trusted while the pin is left to the host.
	always_comb begin
		serTick  = (divCnt_r == DIV_LAST);
		pinLow   = ~pinSync2_r;
		watching = ~pinDrv_r.oe && (guard_r == 2'h0);
		fallEdge = watching && pinPrev_r && ~pinSync2_r;
		riseEdge = watching && ~pinPrev_r && pinSync2_r;
	end

	// Serial clock divider.
	always_comb begin
		divCnt_nxt = serTick ? '0 : divCnt_r + DIV_W'(1);
	end

	// Pending command bookkeeping and the pin sequencer.
	always_comb begin
		state_nxt     = state_r;
		cnt_nxt       = cnt_r;
		guard_nxt     = (guard_r != 2'h0) ? guard_r - 2'h1 : 2'h0;
		pend_nxt      = pend_r;
		kind_nxt      = kind_r;
		access_nxt    = access_r;
		ackCancel_nxt = ackCancel_r;
		ackReady_nxt  = ackReady_r;
		inSync_nxt    = inSync_r;
		pinDrv_nxt    = pinDrv_r;
		cmdAbort_nxt  = 1'b0;
		bitStart_nxt  = 1'b0;
		syncBusy_nxt  = syncBusy_r;
		syncDone_nxt  = 1'b0;

		// A new command clears the access and cancel flags of the previous one; a queued acknowledge stays.
		if (cmdReq.start && !pend_r) begin
			pend_nxt      = 1'b1;
			kind_nxt      = cmdReq.kind;
			access_nxt    = 1'b0;
			ackCancel_nxt = 1'b0;
		end
		if (accessBegin && pend_r) begin
			access_nxt = 1'b1;
		end
		// Completion queues the acknowledge unless it was cancelled.
		if (cmdDone && pend_r) begin
			pend_nxt     = 1'b0;
			access_nxt   = 1'b0;
			ackReady_nxt = !ackCancel_r && !fallEdge;
		end
		// Stop or wait throws away a run-until-active with no acknowledge.
		if (stopWaitExec && pend_r && kind_r == CMD_RUN_UNTIL) begin
			pend_nxt     = 1'b0;
			ackReady_nxt = 1'b0;
		end

		// A falling edge from the host cancels any acknowledge owed.
		if (fallEdge) begin
			ackCancel_nxt = 1'b1;
			ackReady_nxt  = 1'b0;
			if (!pend_r && !ackReady_r) begin
				bitStart_nxt = 1'b1;
			end
		end

		case (state_r)
			ST_IDLE: begin
				// Without a completion the acknowledge waits forever.
				if (fallEdge) begin
					state_nxt = ST_HOST_LOW;
					cnt_nxt   = '0;
				end else if (ackReady_r && !pinLow && watching) begin
					state_nxt    = ST_ACK;
					ackReady_nxt = 1'b0;
					cnt_nxt      = '0;
					pinDrv_nxt   = '{out: 1'b0, oe: 1'b1};
				end
			end
			ST_HOST_LOW: begin
				// Measure the host low time in serial clock cycles.
				if (serTick && cnt_r != SYNC_LOW_MIN) begin
					cnt_nxt = cnt_r + 8'h01;
				end
				if (riseEdge) begin
					cnt_nxt = '0;
					if (pend_r && !access_r && !dwaIsRunKind(kind_r)) begin
						cmdAbort_nxt = 1'b1;
						pend_nxt     = 1'b0;
					end
					// Started accesses and run kinds carry on silently.
					ackCancel_nxt = pend_r;
					if (cnt_r == SYNC_LOW_MIN) begin
						state_nxt    = ST_SYNC_GAP;
						syncBusy_nxt = 1'b1;
					end else begin
						state_nxt = ST_IDLE;
					end
				end
			end
			ST_SYNC_GAP: begin
				// Let the host speedup pulse and bus settle first.
				if (serTick) begin
					cnt_nxt = cnt_r + 8'h01;
					if (cnt_r == SYNC_GAP_LEN - 8'h01) begin
						state_nxt  = ST_SYNC_REF;
						cnt_nxt    = '0;
						pinDrv_nxt = '{out: 1'b0, oe: 1'b1};
					end
				end
			end
			ST_SYNC_REF: begin
				// Timed reference pulse lets the host measure our rate.
				if (serTick) begin
					cnt_nxt = cnt_r + 8'h01;
					if (cnt_r == SYNC_REF_LEN - 8'h01) begin
						state_nxt  = ST_SPEEDUP;
						inSync_nxt = 1'b1;
						pinDrv_nxt = '{out: 1'b1, oe: 1'b1};
					end
				end
			end
			ST_ACK: begin
				// Host edges are invisible here; a read then loses step.
				if (serTick) begin
					cnt_nxt = cnt_r + 8'h01;
					if (cnt_r == ACK_LEN - 8'h01) begin
						state_nxt  = ST_SPEEDUP;
						inSync_nxt = 1'b0;
						pinDrv_nxt = '{out: 1'b1, oe: 1'b1};
					end
				end
			end
			ST_SPEEDUP: begin
				// One serial cycle driven high, then hand the pin back.
				if (serTick) begin
					pinDrv_nxt = '{out: 1'b1, oe: 1'b0};
					guard_nxt  = GUARD_CYCLES;
					cnt_nxt    = '0;
					if (inSync_r) begin
						syncBusy_nxt = 1'b0;
						syncDone_nxt = 1'b1;
						state_nxt    = ST_IDLE;
					end else if (pinLow) begin
						// Host already low: its pulse was a command bit.
						state_nxt    = ST_HOST_LOW;
						bitStart_nxt = 1'b1;
					end else begin
						state_nxt = ST_IDLE;
					end
				end
			end
			default: begin
				state_nxt  = ST_IDLE;
				pinDrv_nxt = '{out: 1'b1, oe: 1'b0};
			end
		endcase
	end

	// State registers.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state_r     <= ST_IDLE;
			divCnt_r    <= '0;
			cnt_r       <= '0;
			guard_r     <= 2'h0;
			pend_r      <= 1'b0;
			kind_r      <= CMD_OTHER;
			access_r    <= 1'b0;
			ackCancel_r <= 1'b0;
			ackReady_r  <= 1'b0;
			inSync_r    <= 1'b0;
			pinDrv_r    <= '{out: 1'b1, oe: 1'b0};
			cmdAbort_r  <= 1'b0;
			bitStart_r  <= 1'b0;
			syncBusy_r  <= 1'b0;
			syncDone_r  <= 1'b0;
		end else begin
			state_r     <= state_nxt;
			divCnt_r    <= divCnt_nxt;
			cnt_r       <= cnt_nxt;
			guard_r     <= guard_nxt;
			pend_r      <= pend_nxt;
			kind_r      <= kind_nxt;
			access_r    <= access_nxt;
			ackCancel_r <= ackCancel_nxt;
			ackReady_r  <= ackReady_nxt;
			inSync_r    <= inSync_nxt;
			pinDrv_r    <= pinDrv_nxt;
			cmdAbort_r  <= cmdAbort_nxt;
			bitStart_r  <= bitStart_nxt;
			syncBusy_r  <= syncBusy_nxt;
			syncDone_r  <= syncDone_nxt;
		end
	end

	// Outputs straight from flops.
	assign pinDrv      = pinDrv_r;
	assign cmdAbort    = cmdAbort_r;
	assign cmdBitStart = bitStart_r;
	assign syncBusy    = syncBusy_r;
	assign syncDone    = syncDone_r;
	assign cmdPending  = pend_r;

endmodule

/* File: test/dwa_checker.sv */
// Assertion checker for the handshake abort block.
// Assumes it is bound into dwa_handshake_abort and sees only its ports.
`timescale 1ns/10ps
module dwa_checker
	import dwa_pkg::*;
#(
	parameter int SER_DIV = 4
) (
	input wire logic       sys_clk,
	input wire logic       reset,
	input wire dwaCmdReq_t cmdReq,
	input wire logic       accessBegin,
	input wire logic       stopWaitExec,
	input wire dwaPinDrv_t pinDrv,
	input wire logic       cmdAbort,
	input wire logic       cmdBitStart,
	input wire logic       syncBusy,
	input wire logic       syncDone,
	input wire logic       cmdPending
);
	dwaCmdKind_t kind_r;
	logic        acc_r;
	int          lowCnt_r;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	// Notes the pending kind, its access start and our low drive length.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			kind_r <= CMD_OTHER;
			acc_r <= 1'b0;
			lowCnt_r <= 0;
		end else begin
			if (cmdReq.start && !cmdPending)
				kind_r <= cmdReq.kind;
			acc_r <= (acc_r | accessBegin) & !(cmdReq.start && !cmdPending);
			lowCnt_r <= (pinDrv.oe && !pinDrv.out) ? lowCnt_r + 1 : 0;
		end
	end
	a_start_pends: assert property (
		cmdReq.start && !cmdPending && !syncBusy |=> cmdPending)
		else $error("command not taken");
	a_abort_kind: assert property (
		cmdAbort |-> kind_r inside {CMD_READ, CMD_WRITE, CMD_OTHER})
		else $error("run kind aborted");
	a_abort_access: assert property (
		cmdAbort |-> !acc_r) else $error("started access aborted");
	a_stop_discard: assert property (
		stopWaitExec && cmdPending && kind_r == CMD_RUN_UNTIL |=> !cmdPending)
		else $error("stop did not discard");
	a_ref_length: assert property (
		$rose(pinDrv.out) && pinDrv.oe && syncBusy |->
		lowCnt_r > 127 * SER_DIV && lowCnt_r <= 128 * SER_DIV)
		else $error("reference pulse length wrong");
	a_sync_end: assert property (
		$fell(syncBusy) |-> syncDone && !pinDrv.oe)
		else $error("sync end wrong");
	a_abort_once: assert property (
		cmdAbort |=> !cmdAbort ##[0:1] !cmdPending)
		else $error("abort did not clear command");
	a_bit_idle: assert property (
		cmdBitStart |-> !cmdPending && !syncBusy)
		else $error("bit start while busy");
	c_sync: cover property (syncDone);
	c_abort: cover property (cmdAbort);
	c_bit: cover property (cmdBitStart);
endmodule

bind dwa_handshake_abort dwa_checker #(.SER_DIV(SER_DIV)) i_dwa_checker (
	.sys_clk, .reset, .cmdReq, .accessBegin, .stopWaitExec, .pinDrv,
	.cmdAbort, .cmdBitStart, .syncBusy, .syncDone, .cmdPending);

/* File: test/dwa_host_pod.sv */
// Host pod model that pulls the debug pin low on demand.
// Assumes a pull-up on the pin, so a release stands for the high pulse.
`timescale 1ns/10ps
module dwa_host_pod (
	input wire logic sys_clk,
	output logic     hostLow
);
	initial hostLow = 1'b0;
	// Holds the pin low for n cycles, then releases it to high.
	task automatic pulse(input int n);
		@(posedge sys_clk);
		hostLow <= 1'b1;
		repeat (n) @(posedge sys_clk);
		hostLow <= 1'b0;
	endtask
endmodule

/* File: test/dwa_handshake_abort_test.sv */
// Self-checking bench for the handshake abort block.
// Assumes the checker is bound in and the host pod model is compiled.
`timescale 1ns/10ps
module dwa_handshake_abort_test;
	import dwa_pkg::*;
	localparam int SD = 2;
	logic       sys_clk = 1'b0;
	logic       reset = 1'b1;
	dwaCmdReq_t cmdReq = '0;
	logic [2:0] ev = '0;
	logic [3:0] seen = '0;
	logic       clrSeen = 1'b0;
	dwaPinDrv_t pinDrv;
	logic       hostLow, cmdAbort, cmdBitStart, syncBusy, syncDone, cmdPending;
	int         num_errors = 0;
	int         checks = 0;
	always #5 sys_clk = ~sys_clk;
	// The pin has a pull-up and is low while any party drives it low.
	wire debugPin = ~hostLow & ~(pinDrv.oe & ~pinDrv.out);
	dwa_host_pod i_dwa_host_pod (.sys_clk(sys_clk), .hostLow(hostLow));
	dwa_handshake_abort #(.SER_DIV(SD)) i_dwa_handshake_abort (
		.sys_clk(sys_clk), .reset(reset), .debugPinIn(debugPin),
		.cmdReq(cmdReq), .accessBegin(ev[0]), .cmdDone(ev[1]),
		.stopWaitExec(ev[2]), .pinDrv(pinDrv), .cmdAbort(cmdAbort),
		.cmdBitStart(cmdBitStart), .syncBusy(syncBusy),
		.syncDone(syncDone), .cmdPending(cmdPending));
	// Remembers abort, acknowledge, bit start and sync end since a clear.
	always @(posedge sys_clk)
		seen <= (clrSeen ? 4'h0 : seen) | {syncDone, cmdBitStart,
			pinDrv.oe & ~pinDrv.out & ~syncBusy, cmdAbort};
	task automatic print_verdict();
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic check(input string nm, input logic exp, got);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %b seen %b", nm, exp, got);
		end
	endtask
	task automatic waitBit(input int b, input int n);
		for (int i = 0; i < n && !seen[b]; i++)
			@(posedge sys_clk);
		check("wait", 1'b1, seen[b]);
		if (!seen[b])
			print_verdict();
	endtask
	task automatic cmd(input dwaCmdKind_t k);
		@(posedge sys_clk);
		clrSeen <= 1'b1;
		cmdReq  <= '{1'b1, k};
		@(posedge sys_clk);
		clrSeen <= 1'b0;
		cmdReq  <= '0;
	endtask
	task automatic fire(input int b);
		@(posedge sys_clk);
		ev[b] <= 1'b1;
		@(posedge sys_clk);
		ev <= '0;
	endtask
	task automatic gap(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// A finished read owes its acknowledge.
	task automatic t_ack();
		cmd(CMD_READ);
		fire(0);
		fire(1);
		waitBit(1, 20);
		check("abort", 1'b0, seen[0]);
		gap(60);
	endtask
	// A short pulse kills a write without a sync.
	task automatic t_short();
		cmd(CMD_WRITE);
		i_dwa_host_pod.pulse(8);
		waitBit(0, 20);
		check("pending", 1'b0, cmdPending);
		check("sync", 1'b0, seen[3]);
		check("bit", 1'b0, seen[2]);
	endtask
	// A long pulse syncs but leaves a run going with no acknowledge.
	task automatic t_sync();
		cmd(CMD_RUN);
		i_dwa_host_pod.pulse(128 * SD + 4);
		waitBit(3, 400);
		check("abort", 1'b0, seen[0]);
		check("pending", 1'b1, cmdPending);
		fire(1);
		gap(40);
		check("ack", 1'b0, seen[1]);
	endtask
	// A started access completes but its acknowledge is dropped.
	task automatic t_access();
		cmd(CMD_READ);
		fire(0);
		i_dwa_host_pod.pulse(8);
		gap(20);
		check("abort", 1'b0, seen[0]);
		fire(1);
		gap(40);
		check("ack", 1'b0, seen[1]);
	endtask
	// A short pulse leaves a single step running with no acknowledge.
	task automatic t_step();
		cmd(CMD_STEP);
		i_dwa_host_pod.pulse(8);
		gap(20);
		check("abort", 1'b0, seen[0]);
		check("pending", 1'b1, cmdPending);
		fire(1);
		gap(40);
		check("ack", 1'b0, seen[1]);
	endtask
	// A long pulse aborts a plain command and then runs the sync.
	task automatic t_syncAbort();
		cmd(CMD_OTHER);
		i_dwa_host_pod.pulse(128 * SD + 4);
		waitBit(0, 20);
		check("pending", 1'b0, cmdPending);
		waitBit(3, 400);
	endtask
	// A host low that overlaps our acknowledge counts as a command bit.
	task automatic t_collide();
		cmd(CMD_WRITE);
		fire(1);
		i_dwa_host_pod.pulse(40);
		waitBit(2, 20);
		check("ack", 1'b1, seen[1]);
		check("abort", 1'b0, seen[0]);
		gap(20);
	endtask
	// Stop discards a run-until; a later pulse starts a new command.
	task automatic t_stop();
		cmd(CMD_RUN_UNTIL);
		fire(2);
		gap(1);
		check("pending", 1'b0, cmdPending);
		gap(40);
		check("ack", 1'b0, seen[1]);
		i_dwa_host_pod.pulse(8);
		waitBit(2, 20);
	endtask
	// Resets, runs each case and reports.
	initial begin
		gap(5);
		reset <= 1'b0;
		t_ack();
		t_short();
		t_sync();
		t_ack();
		t_access();
		t_step();
		t_syncAbort();
		t_collide();
		t_stop();
		print_verdict();
	end
endmodule
